//--- cap_timer_pkg.sv
// constants for the eight-bit capture timer
package cap_timer_pkg;

	// ------------------------------------------------------------
	// register indices and byte addresses (byte address = 4 * index)
	// ------------------------------------------------------------
	localparam logic [7:0]  IDX_COMPARE_CAPTURE_A = 8'h1C;
	localparam logic [7:0]  IDX_CAPTURE_B         = 8'h1D;
	localparam logic [7:0]  IDX_TIMER_CONTROL     = 8'h1E;
	localparam logic [7:0]  IDX_AUX_CONTROL       = 8'h1F;
	localparam logic [11:0] ADDR_COMPARE_CAPTURE_A = {2'h0, IDX_COMPARE_CAPTURE_A, 2'h0};
	localparam logic [11:0] ADDR_CAPTURE_B         = {2'h0, IDX_CAPTURE_B, 2'h0};
	localparam logic [11:0] ADDR_TIMER_CONTROL     = {2'h0, IDX_TIMER_CONTROL, 2'h0};
	localparam logic [11:0] ADDR_AUX_CONTROL       = {2'h0, IDX_AUX_CONTROL, 2'h0};

	// ------------------------------------------------------------
	// timer_control fields
	// ------------------------------------------------------------
	localparam int BIT_AUTO_CAPTURE = 6;
	localparam int BIT_RUN          = 4;
	localparam int BIT_CLK_SEL_LO   = 1;
	localparam int BIT_MODE         = 0;
	// aux_control fields
	localparam int BIT_PRESCALE_DIV = 0;
	localparam int BIT_SUSPENDED    = 1;

	// ------------------------------------------------------------
	// reset values and encodings
	// ------------------------------------------------------------
	localparam logic [7:0] RST_DATA    = 8'hFF;
	localparam logic [7:0] CNT_MAX     = 8'hFF;
	localparam logic [2:0] CLK_SEL_EXT = 3'h7;
	localparam logic       MODE_CAPTURE = 1'b1;

	// ------------------------------------------------------------
	// timing: reference clock, bus clock and tick periods
	// ------------------------------------------------------------
	localparam int FC_HZ         = 20_000_000;
	localparam int PCLK_HZ       = 100_000_000;
	localparam int FC_DIV_CYCLES = PCLK_HZ / FC_HZ;
	localparam int SLOW_TICK_NS  = 409_600;
	localparam int FAST_TICK_NS  = 6_400;
	localparam int SLOW_TICK_CYCLES = SLOW_TICK_NS / (1_000_000_000 / PCLK_HZ);
	localparam int FAST_TICK_CYCLES = FAST_TICK_NS / (1_000_000_000 / PCLK_HZ);
	localparam int SLOWEST_SHIFT = 13;
	localparam int PRESCALE_W    = 14;

endpackage : cap_timer_pkg

//--- timer_events_if.sv
// carrier for the tick and pin-edge events feeding the counter core
`timescale 1ns/1ns
`default_nettype none
interface timer_events_if;
	logic tick;
	logic rise;
	logic fall;
	modport prescaler (output tick);
	modport edges     (output rise, output fall);
	modport core      (input tick, input rise, input fall);
endinterface : timer_events_if
`default_nettype wire

//--- tick_prescaler.sv
// source-clock divider producing one-cycle count ticks
`timescale 1ns/1ns
`default_nettype none
module tick_prescaler #(
	parameter int FC_DIV = cap_timer_pkg::FC_DIV_CYCLES
) (
	input  wire logic       pclk,            // bus clock
	input  wire logic       presetn,         // async reset, active low
	input  wire logic       run,             // divider runs while high
	input  wire logic [2:0] clk_sel,         // source clock select
	input  wire logic       div_sel,         // doubles every tick period
	timer_events_if.prescaler ev             // tick out
);
	localparam int W = cap_timer_pkg::PRESCALE_W;

	logic [15:0]  div_r;
	logic [W-1:0] fc_cnt_r;
	wire          fc_en = (div_r == 16'(FC_DIV - 1));
	// tick period is 2^(13 - sel + div) reference cycles
	wire  [3:0]   shift = 4'(cap_timer_pkg::SLOWEST_SHIFT) - {1'b0, clk_sel} + {3'h0, div_sel};
	wire  [W-1:0] mask  = W'((15'h1 << shift) - 15'h1);

	assign ev.tick = run && fc_en && ((fc_cnt_r & mask) == mask);

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			div_r    <= 16'h0;
			fc_cnt_r <= '0;
		end else if (!run) begin
			div_r    <= 16'h0;
			fc_cnt_r <= '0;
		end else begin
			div_r    <= fc_en ? 16'h0 : div_r + 16'h1;
			fc_cnt_r <= fc_en ? fc_cnt_r + W'(1) : fc_cnt_r;
		end
	end
endmodule : tick_prescaler
`default_nettype wire

//--- pin_edge_detect.sv
// rising and falling edge pulses of the external count input
`timescale 1ns/1ns
`default_nettype none
module pin_edge_detect (
	input  wire logic pclk,                  // bus clock
	input  wire logic presetn,               // async reset, active low
	input  wire logic pin,                   // external count input level
	timer_events_if.edges ev                 // rise and fall pulses
);
	logic prev_r;

	assign ev.rise = pin && !prev_r;
	assign ev.fall = !pin && prev_r;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			prev_r <= 1'b0;
		else
			prev_r <= pin;
	end
endmodule : pin_edge_detect
`default_nettype wire

//--- eight_bit_capture_timer.sv
// eight-bit timer, event counter and capture unit with APB registers
`timescale 1ns/1ns
`default_nettype none
module eight_bit_capture_timer #(
	parameter int FC_DIV = cap_timer_pkg::FC_DIV_CYCLES
) (
	input  wire logic        pclk,            // bus clock, 100 MHz
	input  wire logic        presetn,         // async reset, active low
	input  wire logic        psel,            // apb select
	input  wire logic        penable,         // apb access phase
	input  wire logic        pwrite,          // apb write
	input  wire logic [11:0] paddr,           // apb byte address
	input  wire logic [31:0] pwdata,          // apb write data
	output logic      [31:0] prdata,          // apb read data
	output logic             pready,          // apb ready
	output logic             pslverr,         // apb error on unmapped address
	input  wire logic        ext_count_input, // external pulse pin
	input  wire logic        stop_entry,      // pulse: low-power stop entered
	output logic             timer_irq        // one-cycle interrupt request
);
	// ------------------------------------------------------------
	// registers
	// ------------------------------------------------------------
	logic [7:0]  cnt_r;
	logic [7:0]  compare_capture_a_r;
	logic [7:0]  capture_b_r;
	logic        auto_capture_enable_r;
	logic        run_control_r;
	logic [2:0]  source_clock_select_r;
	logic        op_mode_select_r;
	logic        prescaler_divide_select_r;
	logic        suspended_r;
	logic        irq_r;
	logic [31:0] prdata_r;
	logic        err_r;

	timer_events_if ev ();

	tick_prescaler #(.FC_DIV(FC_DIV)) u_prescaler (
		.pclk    (pclk),
		.presetn (presetn),
		.run     (run_control_r),
		.clk_sel (source_clock_select_r),
		.div_sel (prescaler_divide_select_r),
		.ev      (ev)
	);

	pin_edge_detect u_edges (
		.pclk    (pclk),
		.presetn (presetn),
		.pin     (ext_count_input),
		.ev      (ev)
	);

	// ------------------------------------------------------------
	// apb decode
	// ------------------------------------------------------------
	wire setup     = psel && !penable;
	wire access    = psel && penable;
	wire hit_a     = (paddr == cap_timer_pkg::ADDR_COMPARE_CAPTURE_A);
	wire hit_b     = (paddr == cap_timer_pkg::ADDR_CAPTURE_B);
	wire hit_ctl   = (paddr == cap_timer_pkg::ADDR_TIMER_CONTROL);
	wire hit_aux   = (paddr == cap_timer_pkg::ADDR_AUX_CONTROL);
	wire mapped    = hit_a || hit_b || hit_ctl || hit_aux;
	wire wr        = access && pwrite && mapped;
	wire wr_a      = wr && hit_a;
	wire wr_ctl    = wr && hit_ctl;
	wire wr_aux    = wr && hit_aux;
	wire rd_a      = access && !pwrite && hit_a;

	wire [7:0] ctl_view = {1'b0, auto_capture_enable_r, 1'b0, run_control_r,
	                       source_clock_select_r, op_mode_select_r};
	wire [7:0] aux_view = {6'h0, suspended_r, prescaler_divide_select_r};
	wire [7:0] rd_byte  = hit_a   ? compare_capture_a_r :
	                      hit_b   ? capture_b_r :
	                      hit_ctl ? ctl_view :
	                      hit_aux ? aux_view : 8'h00;

	assign prdata  = prdata_r;
	assign pready  = access;
	assign pslverr = access && err_r;
	assign timer_irq = irq_r;

	// ------------------------------------------------------------
	// counter event decode
	// ------------------------------------------------------------
	wire capture_mode = run_control_r && (op_mode_select_r == cap_timer_pkg::MODE_CAPTURE);
	wire count_mode   = run_control_r && (op_mode_select_r != cap_timer_pkg::MODE_CAPTURE);
	wire event_src    = (source_clock_select_r == cap_timer_pkg::CLK_SEL_EXT);
	wire at_compare   = (cnt_r == compare_capture_a_r);

	// timer/event counting
	wire tmr_match = count_mode && !event_src && at_compare;
	wire evt_match = count_mode && event_src && ev.fall && at_compare;
	wire cm_match  = tmr_match || evt_match;
	wire cm_inc    = count_mode && !cm_match && (event_src ? ev.rise : ev.tick);
	// capture mode events; rise, fall and overflow are blocked while suspended, tick increments are not
	wire cp_rise   = capture_mode && !suspended_r && ev.rise;
	wire cp_fall   = capture_mode && !suspended_r && ev.fall && !ev.rise;
	wire cp_ovf    = capture_mode && !suspended_r && !ev.rise && ev.tick
	                 && (cnt_r == cap_timer_pkg::CNT_MAX);
	wire cp_inc    = capture_mode && !cp_rise && ev.tick;

	wire [7:0] cnt_inc = cnt_r + 8'h01;
	wire [7:0] cnt_nxt = !run_control_r     ? 8'h00 :
	                     (cm_match || cp_rise || cp_ovf) ? 8'h00 :
	                     (cm_inc || cp_inc) ? cnt_inc : cnt_r;
	wire irq_nxt = cm_match || cp_rise || cp_ovf;

	// ------------------------------------------------------------
	// counter and irq
	// ------------------------------------------------------------
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cnt_r <= 8'h00;
			irq_r <= 1'b0;
		end else begin
			cnt_r <= cnt_nxt;
			irq_r <= irq_nxt;
		end
	end

	// ------------------------------------------------------------
	// data registers
	// ------------------------------------------------------------
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			compare_capture_a_r <= cap_timer_pkg::RST_DATA;
		else if (cp_ovf)
			compare_capture_a_r <= cap_timer_pkg::CNT_MAX;
		else if (cp_rise)
			compare_capture_a_r <= cnt_r;
		else if (wr_a)
			compare_capture_a_r <= pwdata[7:0];
	end

	// auto-capture follows increments only, so the post-match zero is skipped
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			capture_b_r <= cap_timer_pkg::RST_DATA;
		else if (cp_fall)
			capture_b_r <= cnt_r;
		else if (cm_inc && auto_capture_enable_r)
			capture_b_r <= cnt_inc;
	end

	// overflow set wins over a same-cycle read
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			suspended_r <= 1'b0;
		else if (cp_ovf)
			suspended_r <= 1'b1;
		else if (rd_a || !run_control_r)
			suspended_r <= 1'b0;
	end

	// ------------------------------------------------------------
	// control registers
	// ------------------------------------------------------------
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			auto_capture_enable_r <= 1'b0;
			source_clock_select_r <= 3'h0;
			op_mode_select_r      <= 1'b0;
		end else if (wr_ctl) begin
			auto_capture_enable_r <= pwdata[cap_timer_pkg::BIT_AUTO_CAPTURE];
			source_clock_select_r <= pwdata[cap_timer_pkg::BIT_CLK_SEL_LO +: 3];
			op_mode_select_r      <= pwdata[cap_timer_pkg::BIT_MODE];
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			run_control_r <= 1'b0;
		else if (stop_entry)
			run_control_r <= 1'b0;
		else if (wr_ctl)
			run_control_r <= pwdata[cap_timer_pkg::BIT_RUN];
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			prescaler_divide_select_r <= 1'b0;
		else if (wr_aux)
			prescaler_divide_select_r <= pwdata[cap_timer_pkg::BIT_PRESCALE_DIV];
	end

	// ------------------------------------------------------------
	// read data captured in the setup cycle
	// ------------------------------------------------------------
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata_r <= 32'h0000_0000;
			err_r    <= 1'b0;
		end else if (setup) begin
			prdata_r <= pwrite ? 32'h0000_0000 : {24'h00_0000, rd_byte};
			err_r    <= !mapped;
		end
	end

endmodule : eight_bit_capture_timer
`default_nettype wire

//--- pulse_source.sv
// external pulse source driving the count pin
`timescale 1ns/1ns
`default_nettype none
module pulse_source (
	input  wire logic pclk, // bus clock
	output logic      pin   // count pin, idles low
);
	initial pin = 1'b0;
	// n pulses, phases given in pclk cycles
	task automatic pulse(input int n, input int hi, input int lo);
		if (hi < 2) hi = 2;
		if (lo < 2) lo = 2;
		repeat (n) begin
			@(posedge pclk);
			pin <= 1'b1;
			repeat (hi) @(posedge pclk);
			pin <= 1'b0;
			repeat (lo - 1) @(posedge pclk);
		end
	endtask : pulse
endmodule : pulse_source
`default_nettype wire

//--- eight_bit_capture_timer_asserts.sv
// port-level assertions for the capture timer
`timescale 1ns/1ns
`default_nettype none
module eight_bit_capture_timer_asserts #(
	parameter int FC_DIV = cap_timer_pkg::FC_DIV_CYCLES
) (
	input wire logic        pclk,            // clock
	input wire logic        presetn,         // reset
	input wire logic        psel,            // apb
	input wire logic        penable,         // apb
	input wire logic        pwrite,          // apb
	input wire logic [11:0] paddr,           // apb
	input wire logic [31:0] pwdata,          // apb
	input wire logic [31:0] prdata,          // apb
	input wire logic        pready,          // apb
	input wire logic        pslverr,         // apb
	input wire logic        ext_count_input, // pin
	input wire logic        stop_entry,      // stop
	input wire logic        timer_irq        // irq
);
	wire        acc    = psel && penable;
	wire        ctl_wr = acc && pwrite && (paddr == cap_timer_pkg::ADDR_TIMER_CONTROL);
	wire        mapped = (paddr[11:4] == 8'h07) && (paddr[1:0] == 2'h0);
	logic       run_r;
	logic       evt_r;
	logic       pin_q_r;
	logic [3:0] fall_age_r;
	// shadow of run and event mode, age of the last pin fall
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			run_r      <= 1'b0;
			evt_r      <= 1'b0;
			pin_q_r    <= 1'b0;
			fall_age_r <= 4'hF;
		end else begin
			run_r      <= ctl_wr ? pwdata[4] : (run_r && !stop_entry);
			evt_r      <= ctl_wr ? (pwdata[3:0] == 4'hE) : evt_r;
			pin_q_r    <= ext_count_input;
			fall_age_r <= (pin_q_r && !ext_count_input) ? 4'h0 : fall_age_r + {3'h0, fall_age_r != 4'hF};
		end
	end
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	irq_one_cycle_a: assert property (timer_irq |=> !timer_irq) else $error("irq longer than one cycle");
	irq_needs_run_a: assert property (!run_r && $past(!run_r) |-> !timer_irq) else $error("irq while stopped");
	evt_at_fall_a: assert property (timer_irq && evt_r |-> fall_age_r <= 4'h4) else $error("event irq off fall");
	zero_wait_a: assert property (acc |-> pready) else $error("access not ready");
	ready_in_access_a: assert property (!acc |-> !pready) else $error("ready outside access");
	unmapped_err_a: assert property (acc && !mapped |-> pslverr && (pwrite || prdata == 32'h0)) else $error("unmapped");
	mapped_ok_a: assert property (acc && mapped |-> !pslverr) else $error("error on mapped word");
	upper_zero_a: assert property (acc && !pwrite |-> prdata[31:8] == 24'h0) else $error("upper read bits set");
	cover property (timer_irq && evt_r);
	cover property (acc && !mapped);
	cover property (timer_irq && !evt_r && run_r);
endmodule : eight_bit_capture_timer_asserts
bind eight_bit_capture_timer eight_bit_capture_timer_asserts #(.FC_DIV(FC_DIV)) chk_i (
	.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
	.pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
	.ext_count_input(ext_count_input), .stop_entry(stop_entry), .timer_irq(timer_irq));
`default_nettype wire

//--- eight_bit_capture_timer_bench.sv
// self-checking bench for the eight-bit capture timer
`timescale 1ns/1ns
`default_nettype none
module eight_bit_capture_timer_bench;
	localparam logic [11:0] REG_A = cap_timer_pkg::ADDR_COMPARE_CAPTURE_A;
	localparam logic [11:0] REG_B = cap_timer_pkg::ADDR_CAPTURE_B;
	localparam logic [11:0] CTL   = cap_timer_pkg::ADDR_TIMER_CONTROL;
	localparam logic [11:0] AUX   = cap_timer_pkg::ADDR_AUX_CONTROL;
	logic        pclk, presetn, psel, penable, pwrite, stop_entry, timer_irq, pready, pslverr, pin, er;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, rd;
	logic [7:0]  rv [4] = '{8'hFF, 8'hFF, 8'h00, 8'h00};
	int          failures, total_checks, irq_n, cyc, t0, c, e, n0;
	eight_bit_capture_timer #(.FC_DIV(1)) uut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.ext_count_input(pin), .stop_entry(stop_entry), .timer_irq(timer_irq));
	pulse_source src (.pclk(pclk), .pin(pin));
	initial begin
		pclk = 1'b0;
		forever #5 pclk = ~pclk;
	end
	always @(posedge pclk) begin
		cyc <= cyc + 1;
		if (timer_irq === 1'b1) irq_n <= irq_n + 1;
	end
	// count period in pclk cycles with the fc divider set to one
	function automatic int tick_cycles(input int s, input int d);
		return (128 << (6 - s)) << d;
	endfunction : tick_cycles
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		int k;
		@(posedge pclk);
		psel    <= 1'b1;
		penable <= 1'b0;
		pwrite  <= w;
		paddr   <= a;
		pwdata  <= d;
		@(posedge pclk);
		penable <= 1'b1;
		k = 0;
		do begin
			@(posedge pclk);
			k++;
		end while (pready !== 1'b1 && k < 50);
		if (k >= 50) begin
			failures++;
			$display("MISMATCH apb_ready expected 1 seen %0b", pready);
		end
		rd = prdata;
		er = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
	endtask : apb
	task automatic chk(input string n, input logic [31:0] x, input logic [31:0] g);
		total_checks++;
		if (g !== x) begin
			failures++;
			$display("MISMATCH %s expected %0h seen %0h", n, x, g);
		end
	endtask : chk
	task automatic wait_irq(input int lim);
		int m;
		m = irq_n;
		for (int i = 0; i < lim && irq_n == m; i++) @(posedge pclk);
	endtask : wait_irq
	task automatic print_verdict;
		$display("checks %0d failures %0d", total_checks, failures);
		if (failures == 0 && total_checks > 0) $display("All tests passed");
		else $display("Some tests failed");
		$finish;
	endtask : print_verdict
	initial begin
		repeat (100000) @(posedge pclk);
		failures++;
		print_verdict();
	end
	initial begin
		{psel, penable, pwrite, stop_entry, presetn} = 5'h00;
		paddr = 12'h000;
		pwdata = 32'h0;
		c = $urandom(30309);
		repeat (2) @(posedge pclk);
		presetn <= 1'b1;
		apb(1'b1, REG_B, 32'h12);
		for (int i = 0; i < 4; i++) begin
			apb(1'b0, REG_A + 12'(4 * i), 32'h0);
			chk("reset_value", {24'h0, rv[i]}, rd);
		end
		apb(1'b0, 12'h080, 32'h0);
		chk("unmapped_err", 32'h1, {31'h0, er});
		chk("unmapped_data", 32'h0, rd);
		// clock codes 0 to 6, last pass code 6 again with the divide bit
		for (int s = 0; s < 8; s++) begin
			apb(1'b1, AUX, {31'h0, s == 7});
			apb(1'b1, REG_A, 32'h2);
			apb(1'b1, CTL, 32'h10 | 32'((s == 7 ? 6 : s) << 1));
			t0 = cyc;
			e = 2 * tick_cycles(s == 7 ? 6 : s, s == 7);
			wait_irq(20000);
			chk("timer_period", 32'h1, {31'h0, (cyc - t0 >= e - 2) && (cyc - t0 <= e + 6)});
			apb(1'b1, CTL, 32'h0);
		end
		apb(1'b1, AUX, 32'h0);
		repeat (3) begin
			c = 2 + $urandom % 4;
			apb(1'b1, REG_A, 32'(c));
			apb(1'b1, CTL, 32'h5C);
			repeat (200 + $urandom % 800) @(posedge pclk);
			apb(1'b0, REG_B, 32'h0);
			chk("auto_capture", 32'h1, {31'h0, rd >= 1 && rd <= c});
			apb(1'b1, CTL, 32'h0);
		end
		c = 2 + $urandom % 3;
		apb(1'b1, REG_A, 32'(c));
		apb(1'b1, CTL, 32'h5E);
		n0 = irq_n;
		src.pulse(c - 1, 3, 3);
		apb(1'b0, REG_B, 32'h0);
		chk("event_count", 32'(c - 1), rd);
		chk("event_early_irq", 32'(n0), 32'(irq_n));
		src.pulse(1, 3, 3);
		repeat (4) @(posedge pclk);
		chk("event_match_irq", 32'(n0 + 1), 32'(irq_n));
		apb(1'b0, REG_B, 32'h0);
		chk("event_zero_kept", 32'(c), rd);
		apb(1'b1, CTL, 32'h0);
		apb(1'b1, CTL, 32'h1D);
		n0 = irq_n;
		// read capture_b after the first rise but before the falling edge of the same pulse
		fork
			src.pulse(1, 400, 300);
			begin
				repeat (20) @(posedge pclk);
				apb(1'b0, REG_B, 32'h0);
			end
		join
		chk("first_rise_b", 32'(c), rd);
		chk("first_rise_irq", 32'(n0 + 1), 32'(irq_n));
		src.pulse(1, 400, 300);
		apb(1'b0, REG_B, 32'h0);
		chk("fall_capture", 32'h1, {31'h0, rd >= 3 && rd <= 4});
		apb(1'b0, REG_A, 32'h0);
		chk("rise_capture", 32'h1, {31'h0, rd >= 5 && rd <= 6});
		wait_irq(34000);
		chk("overflow_irq", 32'(n0 + 3), 32'(irq_n));
		src.pulse(1, 400, 300);
		chk("suspended_edges", 32'(n0 + 3), 32'(irq_n));
		apb(1'b0, AUX, 32'h0);
		chk("suspended_flag", 32'h2, rd & 32'h2);
		apb(1'b0, REG_A, 32'h0);
		chk("overflow_value", 32'hFF, rd);
		src.pulse(1, 400, 300);
		chk("resumed_edges", 32'(n0 + 4), 32'(irq_n));
		stop_entry <= 1'b1;
		@(posedge pclk);
		stop_entry <= 1'b0;
		apb(1'b0, CTL, 32'h0);
		chk("stop_clears_run", 32'h0, {31'h0, rd[4]});
		print_verdict();
	end
endmodule : eight_bit_capture_timer_bench
`default_nettype wire
